// *** inc/spsw_consts.vh ***
// Constants of the serial status word block
`ifndef SPSW_CONSTS_VH
`define SPSW_CONSTS_VH

// ****************************************
// Register word addresses
// ****************************************
`define SPSW_REG_CTRL      3'h0
`define SPSW_REG_DEV_STAT  3'h1
`define SPSW_REG_IF_STAT   3'h2
`define SPSW_REG_IRQ_STAT  3'h3
`define SPSW_REG_IRQ_MASK  3'h4
`define SPSW_REG_LAST_WORD 3'h5

// ****************************************
// Control fields
// ****************************************
`define SPSW_CTRL_SEND   0
`define SPSW_CTRL_SHORT  1
`define SPSW_CTRL_SWRST  2
`define SPSW_CTRL_RST    2'h0

// ****************************************
// Device status bits
// ****************************************
`define SPSW_DS_FULL     7
`define SPSW_DS_RDONE    6
`define SPSW_DS_UPPER    5
`define SPSW_DS_LOWER    4
`define SPSW_DS_APOR     3
`define SPSW_DS_CONV     2
`define SPSW_DS_ROM      1
`define SPSW_DS_POR      0
`define SPSW_DS_RST      8'h09

// ****************************************
// Interface status bits
// ****************************************
`define SPSW_IF_NRDY     7
`define SPSW_IF_CLKCNT   4
`define SPSW_IF_LOW_MSB  3
`define SPSW_IF_RST      8'h00

// ****************************************
// Frame geometry
// ****************************************
`define SPSW_LONG_LEN    5'h10
`define SPSW_SHORT_LEN   5'h08
`define SPSW_BYTE_MASK   16'h0007
`define SPSW_CNT_MAX     16'hffff

`endif

// *** rtl/spsw_shifter.v ***
// Status shift register, MSB first
`timescale 1ns/100ps
`default_nettype none

module spsw_shifter (
  input  wire        i_ref_clk,  // Device clock
  input  wire        i_reset_n,  // Async reset, active low
  input  wire        i_load,     // Take a snapshot
  input  wire [15:0] i_word,     // Snapshot value
  input  wire        i_shift,    // Advance one bit
  output reg         o_msb       // Bit on the line
);

  reg [15:0] word_r;

  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      word_r <= 16'h0000;
      o_msb  <= 1'b0;
    end else if (i_load) begin
      word_r <= i_word;
      o_msb  <= i_word[15];
    end else if (i_shift) begin
      word_r <= {word_r[14:0], 1'b0};
      o_msb  <= word_r[14];
    end
  end

endmodule // spsw_shifter

`default_nettype wire

// *** rtl/spsw_status_top.v ***
// Serial status word source with Avalon-MM register access
// What this block does
// - With sending enabled, the status word goes out on the serial output MSB first during the instruction phase.
// - The instruction length setting picks the word layout; the 16-bit layout is used for long instructions.
// - Word bits 15 and 14 are zero and bit 13 is the buffer full flag.
// - Word bit 12 is the buffer read done flag.
// - Word bit 11 is set once an upper threshold hit has been seen.
// - Word bit 10 is set once a lower threshold hit has been seen.
// - Word bit 9 is the conversion fault flag, 1 after an error and 0 once cleared.
// - The conversion fault flag is set by a too-short conversion period or a processing error.
// - Word bit 8 is 1 while the internal ROM check fails.
// - Word bit 7 is the analog power-up event flag, 1 after the event and 0 once cleared.
// - The analog power-up flag rises at power-up, logic supply dip, reference dip or software reset.
// - Word bit 6 is the power-up flag, set at power-up, logic supply dip or software reset.
// - Word bit 5 flags a transaction started before digital initialisation finished.
// - Word bit 4 flags a transaction with a wrong number of serial clock edges.
// - Word bits 3 to 0 are the checksum, read-only write, partial access and invalid address faults.
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
`include "spsw_consts.vh"

module spsw_status_top (
  input  wire        i_ref_clk,              // 250 MHz device clock
  input  wire        i_reset_n,              // Async reset, active low
  // Serial link pins
  input  wire        i_spi_sclk,             // Serial clock pin
  input  wire        i_spi_cs_n,             // Chip select pin, active low
  output wire        o_spi_sdo,              // Serial data out
  output reg         o_spi_sdo_oe,           // Serial out enable
  // Device events, same clock
  input  wire        i_buf_full,             // Result buffer full level
  input  wire        i_buf_read_done,        // Buffer fully read level
  input  wire        i_upper_threshold_hit,  // Upper threshold pulse
  input  wire        i_lower_threshold_hit,  // Lower threshold pulse
  input  wire        i_conv_period_short,    // Conversion period too short
  input  wire        i_dsp_fault,            // Processing error pulse
  input  wire        i_rom_check_fail,       // ROM check fail level
  input  wire        i_init_done,            // Digital init finished
  input  wire        i_crc_fault,            // Checksum fault pulse
  input  wire        i_readonly_write_fault, // Read-only write pulse
  input  wire        i_partial_access_fault, // Partial access pulse
  input  wire        i_addr_invalid_fault,   // Invalid address pulse
  // Analog comparators, asynchronous
  input  wire        i_logic_supply_low,     // Logic supply below threshold
  input  wire        i_ref_low,              // Reference below threshold
  // Avalon-MM slave
  input  wire [2:0]  i_avs_address,          // Word address
  input  wire        i_avs_read,             // Read request
  input  wire        i_avs_write,            // Write request
  input  wire [31:0] i_avs_writedata,        // Write data
  output reg  [31:0] o_avs_readdata,         // Read data
  output reg         o_avs_waitrequest,      // Wait request
  output reg         o_irq                   // Interrupt level
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire [3:0] sync_w;
  wire       cs_n_s;
  wire       sclk_s;
  wire       supply_low_s;
  wire       ref_low_s;

  spsw_sync #(.W(4)) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_async   ({i_spi_cs_n, i_spi_sclk, i_logic_supply_low, i_ref_low}),
    .o_sync    (sync_w)
  );

  assign cs_n_s       = sync_w[3];
  assign sclk_s       = sync_w[2];
  assign supply_low_s = sync_w[1];
  assign ref_low_s    = sync_w[0];

  reg cs_n_d_r;
  reg sclk_d_r;
  reg supply_low_d_r;
  reg ref_low_d_r;

  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cs_n_d_r       <= 1'b1;
      sclk_d_r       <= 1'b1;
      supply_low_d_r <= 1'b1;
      ref_low_d_r    <= 1'b1;
    end else begin
      cs_n_d_r       <= cs_n_s;
      sclk_d_r       <= sclk_s;
      supply_low_d_r <= supply_low_s;
      ref_low_d_r    <= ref_low_s;
    end
  end

  wire frame_start = cs_n_d_r & ~cs_n_s;
  wire frame_end   = ~cs_n_d_r & cs_n_s;
  wire sclk_rise   = ~cs_n_s & ~sclk_d_r & sclk_s;
  wire sclk_fall   = ~cs_n_s & sclk_d_r & ~sclk_s;
  wire supply_dip  = ~supply_low_d_r & supply_low_s;
  wire ref_dip     = ~ref_low_d_r & ref_low_s;

  // ****************************************
  // Bus decode
  // ****************************************
  reg  [1:0]  ctrl_r;
  reg  [7:0]  dev_stat_r;
  reg  [7:0]  if_stat_r;
  reg  [15:0] irq_stat_r;
  reg  [15:0] irq_mask_r;
  reg  [15:0] last_word_r;
  reg         swrst_r;

  wire bus_req  = i_avs_read | i_avs_write;
  wire bus_done = bus_req & ~o_avs_waitrequest;
  wire wr_done  = bus_done & i_avs_write;
  wire rd_done  = bus_done & i_avs_read;

  function sel;
    input [2:0] addr;
    input [2:0] reg_addr;
    begin
      sel = (addr == reg_addr);
    end
  endfunction

  // One wait cycle, then the answer at the next edge
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h00000000;
    end else begin
      o_avs_waitrequest <= ~(bus_req & o_avs_waitrequest);
      if (i_avs_read & o_avs_waitrequest) begin
        case (i_avs_address)
          `SPSW_REG_CTRL:      o_avs_readdata <= {30'h00000000, ctrl_r};
          `SPSW_REG_DEV_STAT:  o_avs_readdata <= {24'h000000, dev_stat_r};
          `SPSW_REG_IF_STAT:   o_avs_readdata <= {24'h000000, if_stat_r};
          `SPSW_REG_IRQ_STAT:  o_avs_readdata <= {16'h0000, irq_stat_r};
          `SPSW_REG_IRQ_MASK:  o_avs_readdata <= {16'h0000, irq_mask_r};
          `SPSW_REG_LAST_WORD: o_avs_readdata <= {16'h0000, last_word_r};
          default:             o_avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Control; the software reset field is a self-clearing pulse
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_r     <= `SPSW_CTRL_RST;
      irq_mask_r <= 16'h0000;
      swrst_r    <= 1'b0;
    end else begin
      swrst_r <= wr_done & sel(i_avs_address, `SPSW_REG_CTRL) & i_avs_writedata[`SPSW_CTRL_SWRST];
      if (wr_done & sel(i_avs_address, `SPSW_REG_CTRL)) begin
        ctrl_r <= i_avs_writedata[`SPSW_CTRL_SHORT:`SPSW_CTRL_SEND];
      end
      if (wr_done & sel(i_avs_address, `SPSW_REG_IRQ_MASK)) begin
        irq_mask_r <= i_avs_writedata[15:0];
      end
    end
  end

  wire       dev_clr_wr = wr_done & sel(i_avs_address, `SPSW_REG_DEV_STAT);
  wire       if_clr_wr  = wr_done & sel(i_avs_address, `SPSW_REG_IF_STAT);
  wire [7:0] dev_clr    = dev_clr_wr ? i_avs_writedata[7:0] : 8'h00;
  wire [7:0] if_clr     = if_clr_wr ? i_avs_writedata[7:0] : 8'h00;

  // ****************************************
  // Device status
  // ****************************************
  // Sticky flags clear by writing one; a set in the same cycle wins
  wire [7:0] dev_set;
  assign dev_set[`SPSW_DS_FULL]  = 1'b0;
  assign dev_set[`SPSW_DS_RDONE] = 1'b0;
  assign dev_set[`SPSW_DS_UPPER] = i_upper_threshold_hit;
  assign dev_set[`SPSW_DS_LOWER] = i_lower_threshold_hit;
  assign dev_set[`SPSW_DS_APOR]  = supply_dip | ref_dip | swrst_r;
  assign dev_set[`SPSW_DS_CONV]  = i_conv_period_short | i_dsp_fault;
  assign dev_set[`SPSW_DS_ROM]   = 1'b0;
  assign dev_set[`SPSW_DS_POR]   = supply_dip | swrst_r;

  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dev_stat_r <= `SPSW_DS_RST;
    end else begin
      dev_stat_r <= (dev_stat_r & ~dev_clr) | dev_set;
      // Live levels follow their sources
      dev_stat_r[`SPSW_DS_FULL]  <= i_buf_full;
      dev_stat_r[`SPSW_DS_RDONE] <= i_buf_read_done;
      dev_stat_r[`SPSW_DS_ROM]   <= i_rom_check_fail;
    end
  end

  // ****************************************
  // Frame tracking
  // ****************************************
  reg  [15:0] edge_cnt_r;
  reg  [4:0]  bit_cnt_r;
  reg  [4:0]  instr_len_r;
  reg         sending_r;

  wire [4:0] instr_len = ctrl_r[`SPSW_CTRL_SHORT] ? `SPSW_SHORT_LEN : `SPSW_LONG_LEN;
  wire clk_cnt_bad = frame_end &
                     ((edge_cnt_r < {11'h000, instr_len_r}) |
                      ((edge_cnt_r & `SPSW_BYTE_MASK) != 16'h0000));

  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      edge_cnt_r  <= 16'h0000;
    end else if (frame_start) begin
      edge_cnt_r  <= 16'h0000;
    end else if (sclk_rise && edge_cnt_r != `SPSW_CNT_MAX) begin
      edge_cnt_r  <= edge_cnt_r + 16'h0001;
    end
  end

  // ****************************************
  // Interface status
  // ****************************************
  wire [7:0] if_set;
  assign if_set[`SPSW_IF_NRDY]   = frame_start & ~i_init_done;
  assign if_set[6:5]             = 2'h0;
  assign if_set[`SPSW_IF_CLKCNT] = clk_cnt_bad;
  assign if_set[`SPSW_IF_LOW_MSB:0] = {i_crc_fault, i_readonly_write_fault,
                                       i_partial_access_fault, i_addr_invalid_fault};

  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      if_stat_r <= `SPSW_IF_RST;
    end else begin
      if_stat_r <= (if_stat_r & ~if_clr) | if_set;
    end
  end

  // ****************************************
  // Status word assembly
  // ****************************************
  wire [15:0] long_word = {2'h0,
                           dev_stat_r[`SPSW_DS_FULL],
                           dev_stat_r[`SPSW_DS_RDONE],
                           dev_stat_r[`SPSW_DS_UPPER],
                           dev_stat_r[`SPSW_DS_LOWER],
                           dev_stat_r[`SPSW_DS_CONV],
                           dev_stat_r[`SPSW_DS_ROM],
                           dev_stat_r[`SPSW_DS_APOR],
                           dev_stat_r[`SPSW_DS_POR],
                           if_stat_r[`SPSW_IF_NRDY],
                           if_stat_r[`SPSW_IF_CLKCNT],
                           if_stat_r[`SPSW_IF_LOW_MSB:0]};
  // Short layout sits in the upper byte so MSB-first still holds
  wire [15:0] short_word = {1'b0, dev_stat_r[`SPSW_DS_POR], if_stat_r[`SPSW_IF_NRDY],
                            if_stat_r[`SPSW_IF_CLKCNT], if_stat_r[`SPSW_IF_LOW_MSB:0], 8'h00};
  wire [15:0] word_now = ctrl_r[`SPSW_CTRL_SHORT] ? short_word : long_word;

  // ****************************************
  // Serial output
  // ****************************************
  // Shift on falling edges so the host samples stable data on rising ones
  wire shift_en = sending_r & sclk_fall & (bit_cnt_r < instr_len_r);

  spsw_shifter u_shift (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_load    (frame_start),
    .i_word    (word_now),
    .i_shift   (shift_en),
    .o_msb     (o_spi_sdo)
  );

  wire [4:0] bit_cnt_nxt = frame_start ? 5'h00 :
                           (shift_en ? bit_cnt_r + 5'h01 : bit_cnt_r);

  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bit_cnt_r    <= 5'h00;
      instr_len_r  <= `SPSW_LONG_LEN;
      sending_r    <= 1'b0;
      o_spi_sdo_oe <= 1'b0;
      last_word_r  <= 16'h0000;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      if (frame_start) begin
        instr_len_r <= instr_len;
        sending_r   <= ctrl_r[`SPSW_CTRL_SEND];
        last_word_r <= word_now;
      end else if (frame_end) begin
        sending_r   <= 1'b0;
      end
      // Release the line once the instruction phase is over
      o_spi_sdo_oe <= frame_start ? ctrl_r[`SPSW_CTRL_SEND] :
                      (sending_r & ~frame_end & (bit_cnt_nxt < instr_len_r));
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  // Any word bit rising raises its sticky bit; a read clears, a set wins
  reg  [15:0] word_d_r;
  wire        irq_rd_clr = rd_done & sel(i_avs_address, `SPSW_REG_IRQ_STAT);
  wire [15:0] irq_rise   = long_word & ~word_d_r;
  wire [15:0] irq_nxt    = (irq_rd_clr ? 16'h0000 : irq_stat_r) | irq_rise;

  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      word_d_r   <= 16'h0000;
      irq_stat_r <= 16'h0000;
      o_irq      <= 1'b0;
    end else begin
      word_d_r   <= long_word;
      irq_stat_r <= irq_nxt;
      o_irq      <= |(irq_nxt & irq_mask_r);
    end
  end

endmodule // spsw_status_top

`default_nettype wire

// *** rtl/spsw_sync.v ***
// Two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/100ps
`default_nettype none

module spsw_sync #(
  parameter W = 4
) (
  input  wire         i_ref_clk,  // Device clock
  input  wire         i_reset_n,  // Async reset, active low
  input  wire [W-1:0] i_async,    // Levels from pins
  output reg  [W-1:0] o_sync      // Synchronised levels
);

  reg [W-1:0] meta_r;

  // First stage is read only by the second
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_r <= {W{1'b1}};
      o_sync <= {W{1'b1}};
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule // spsw_sync

`default_nettype wire

// *** tb/spsw_host_model.sv ***
// Behavioural serial host that clocks status frames out of the device
`timescale 1ns/100ps
`default_nettype none

module spsw_host_model (
  input  wire logic i_clk,     // Device clock, paces the host
  input  wire logic i_sdo,     // Serial data from device
  input  wire logic i_sdo_oe,  // Device drives the line
  output var logic  o_sclk,    // Serial clock, idles low
  output var logic  o_cs_n     // Chip select, active low
);
  // ****************************************
  // Frame driver
  // ****************************************
  logic last_r = 1'h0;
  // Released line must not mimic the last bit
  wire  line = i_sdo_oe ? i_sdo : ~last_r;

  initial begin
    o_sclk = 1'h0;
    o_cs_n = 1'h1;
  end

  always @(posedge i_clk) begin
    if (i_sdo_oe) last_r <= i_sdo;
  end

  // Half period of 8 device clocks keeps well above the sync limit
  task automatic frame(input int n, output logic [15:0] w, output logic seen);
    w = 16'h0;
    seen = 1'h0;
    @(posedge i_clk);
    o_cs_n <= 1'h0;
    repeat (10) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      w = {w[14:0], line};
      seen = seen | i_sdo_oe;
      o_sclk <= 1'h1;
      repeat (8) @(posedge i_clk);
      o_sclk <= 1'h0;
      repeat (8) @(posedge i_clk);
    end
    o_cs_n <= 1'h1;
    repeat (12) @(posedge i_clk);
  endtask
endmodule // spsw_host_model

`default_nettype wire

// *** tb/spsw_status_monitor.sv ***
// Concurrent checks on the bus and serial pins of the status word block
`timescale 1ns/100ps
`default_nettype none

module spsw_status_monitor (
  input wire logic        i_ref_clk,         // Device clock
  input wire logic        i_reset_n,         // Async reset, active low
  input wire logic        i_spi_sclk,        // Serial clock pin
  input wire logic        i_spi_cs_n,        // Chip select pin
  input wire logic        o_spi_sdo,         // Serial data out
  input wire logic        o_spi_sdo_oe,      // Serial out enable
  input wire logic [2:0]  i_avs_address,     // Word address
  input wire logic        i_avs_read,        // Read request
  input wire logic        i_avs_write,       // Write request
  input wire logic [31:0] o_avs_readdata,    // Read data
  input wire logic        o_avs_waitrequest  // Wait request
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_req;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  // Synchroniser plus frame-end flop need margin before oe must be gone
  sequence s_cs_idle;
    i_spi_cs_n [*6];
  endsequence

  property p_answer; s_req |=> !o_avs_waitrequest; endproperty
  a_answer: assert property (p_answer) else $error("Bus request not answered next cycle");
  property p_one_cycle; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("Wait request low for more than one cycle");
  property p_no_spont; !(i_avs_read || i_avs_write) && o_avs_waitrequest |=> o_avs_waitrequest; endproperty
  a_no_spont: assert property (p_no_spont) else $error("Bus answer without a request");
  property p_rd_hold; $changed(o_avs_readdata) |-> i_avs_read && !o_avs_waitrequest; endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("Read data changed outside a read");
  property p_unmapped;
    i_avs_read && !o_avs_waitrequest && (i_avs_address > 3'h5) |-> o_avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("Unmapped read returned nonzero");
  property p_oe_idle; s_cs_idle |-> !o_spi_sdo_oe; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("Serial output driven without a frame");
  property p_oe_start; $rose(o_spi_sdo_oe) |-> !$past(i_spi_cs_n, 2); endproperty
  a_oe_start: assert property (p_oe_start) else $error("Serial output enabled before select");
  property p_first_zero; $rose(o_spi_sdo_oe) |-> !o_spi_sdo; endproperty
  a_first_zero: assert property (p_first_zero) else $error("Leading word bit not zero");
  property p_shift;
    o_spi_sdo_oe && $past(o_spi_sdo_oe) && $changed(o_spi_sdo) |-> !$past(i_spi_sclk, 2);
  endproperty
  a_shift: assert property (p_shift) else $error("Serial bit moved without a falling clock");
endmodule // spsw_status_monitor

`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the serial status word block
`timescale 1ns/100ps
`default_nettype none
`include "spsw_consts.vh"

module tb_top;
  // ****************************************
  // Wiring
  // ****************************************
  logic        i_ref_clk = 1'h0;
  logic        i_reset_n = 1'h0;
  wire         i_spi_sclk, i_spi_cs_n, o_spi_sdo, o_spi_sdo_oe, o_irq, o_avs_waitrequest;
  wire  [31:0] o_avs_readdata;
  logic        i_buf_full = 1'h0, i_buf_read_done = 1'h0, i_rom_check_fail = 1'h0, i_init_done = 1'h1;
  logic        i_upper_threshold_hit = 1'h0, i_lower_threshold_hit = 1'h0, i_conv_period_short = 1'h0;
  logic        i_dsp_fault = 1'h0, i_crc_fault = 1'h0, i_readonly_write_fault = 1'h0;
  logic        i_partial_access_fault = 1'h0, i_addr_invalid_fault = 1'h0;
  logic        i_logic_supply_low = 1'h0, i_ref_low = 1'h0, i_avs_read = 1'h0, i_avs_write = 1'h0;
  logic [2:0]  i_avs_address = 3'h0;
  logic [31:0] i_avs_writedata = 32'h0, q;
  logic [7:0]  ed, ei;
  logic [15:0] w;
  logic        s;
  int          miscompares = 0, num_checks = 0;

  spsw_status_top dut (.i_ref_clk, .i_reset_n, .i_spi_sclk, .i_spi_cs_n, .o_spi_sdo, .o_spi_sdo_oe,
    .i_buf_full, .i_buf_read_done, .i_upper_threshold_hit, .i_lower_threshold_hit, .i_conv_period_short,
    .i_dsp_fault, .i_rom_check_fail, .i_init_done, .i_crc_fault, .i_readonly_write_fault,
    .i_partial_access_fault, .i_addr_invalid_fault, .i_logic_supply_low, .i_ref_low, .i_avs_address,
    .i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .o_irq);
  spsw_host_model host (.i_clk(i_ref_clk), .i_sdo(o_spi_sdo), .i_sdo_oe(o_spi_sdo_oe),
    .o_sclk(i_spi_sclk), .o_cs_n(i_spi_cs_n));

  initial forever #2 i_ref_clk = ~i_ref_clk;

  // ****************************************
  // Tasks and tests
  // ****************************************
  task automatic print_verdict;
    if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] a);
    num_checks++;
    if (a !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, a);
    end
  endtask

  // Request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d, output logic [31:0] r);
    int   n;
    logic ack;
    n = 0;
    ack = 1'h0;
    @(posedge i_ref_clk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    // Waitrequest looked at mid-cycle, so the edge that launches it is not raced
    do begin
      @(negedge i_ref_clk);
      ack = (o_avs_waitrequest === 1'h0);
      @(posedge i_ref_clk);
      n++;
    end while (!ack && n < 50);
    // Read data holds past the answering edge until the next read
    r = o_avs_readdata;
    if (n >= 50) miscompares++;
    i_avs_read <= 1'h0;
    i_avs_write <= 1'h0;
  endtask

  task automatic chkrd(input logic [2:0] a, input logic [31:0] e, input string nm);
    logic [31:0] r;
    bus(1'h0, a, 32'h0, r);
    chk(nm, e, r);
  endtask

  task automatic chkall(input string nm, input logic sh);
    logic [15:0] e;
    e = sh ? {8'h0, 1'h0, ed[0], ei[7], ei[4], ei[3:0]}
           : {2'h0, ed[7:4], ed[2], ed[1], ed[3], ed[0], ei[7], ei[4], ei[3:0]};
    chkrd(`SPSW_REG_DEV_STAT, {24'h0, ed}, {nm, "_dev"});
    chkrd(`SPSW_REG_IF_STAT, {24'h0, ei}, {nm, "_if"});
    host.frame(sh ? 8 : 16, w, s);
    chk({nm, "_word"}, {15'h0, 1'h1, e}, {15'h0, s, w});
    if (!sh) chkrd(`SPSW_REG_LAST_WORD, {16'h0, e}, {nm, "_last"});
  endtask

  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_reset_n <= 1'h1;
    ed = 8'h09;
    ei = 8'h00;
    chkrd(`SPSW_REG_DEV_STAT, 32'h9, "dev_rst");
    chkrd(`SPSW_REG_CTRL, 32'h0, "ctrl_rst");
    chkrd(3'h7, 32'h0, "unmapped");
    host.frame(16, w, s);
    chk("oe_disabled", 32'h0, {31'h0, s});
    bus(1'h1, `SPSW_REG_CTRL, 32'h1, q);
    @(posedge i_ref_clk);
    {i_buf_full, i_upper_threshold_hit, i_conv_period_short, i_crc_fault} <= 4'hf;
    @(posedge i_ref_clk);
    {i_upper_threshold_hit, i_conv_period_short, i_crc_fault} <= 3'h0;
    ed = 8'had;
    ei = 8'h08;
    chkall("a", 1'h0);
    bus(1'h1, `SPSW_REG_DEV_STAT, 32'hff, q);
    bus(1'h1, `SPSW_REG_IF_STAT, 32'hff, q);
    @(posedge i_ref_clk);
    {i_buf_full, i_buf_read_done, i_rom_check_fail, i_lower_threshold_hit, i_dsp_fault} <= 5'h0f;
    {i_readonly_write_fault, i_partial_access_fault, i_addr_invalid_fault} <= 3'h7;
    @(posedge i_ref_clk);
    {i_lower_threshold_hit, i_dsp_fault, i_readonly_write_fault, i_partial_access_fault} <= 4'h0;
    i_addr_invalid_fault <= 1'h0;
    ed = 8'h56;
    ei = 8'h07;
    chkall("b", 1'h0);
    bus(1'h1, `SPSW_REG_DEV_STAT, 32'hff, q);
    bus(1'h1, `SPSW_REG_IF_STAT, 32'hff, q);
    {i_buf_read_done, i_rom_check_fail, i_init_done} <= 3'h0;
    host.frame(16, w, s);
    i_init_done <= 1'h1;
    host.frame(12, w, s);
    ed = 8'h00;
    ei = 8'h90;
    chkall("c", 1'h0);
    bus(1'h1, `SPSW_REG_CTRL, 32'h7, q);
    chkrd(`SPSW_REG_CTRL, 32'h3, "ctrl_selfclr");
    ed = 8'h09;
    chkall("d", 1'h1);
    bus(1'h1, `SPSW_REG_CTRL, 32'h1, q);
    bus(1'h1, `SPSW_REG_DEV_STAT, 32'hff, q);
    i_ref_low <= 1'h1;
    repeat (8) @(posedge i_ref_clk);
    chkrd(`SPSW_REG_DEV_STAT, 32'h08, "ref_dip");
    i_ref_low <= 1'h0;
    bus(1'h1, `SPSW_REG_DEV_STAT, 32'hff, q);
    i_logic_supply_low <= 1'h1;
    repeat (8) @(posedge i_ref_clk);
    chkrd(`SPSW_REG_DEV_STAT, 32'h09, "supply_dip");
    i_logic_supply_low <= 1'h0;
    bus(1'h0, `SPSW_REG_IRQ_STAT, 32'h0, q);
    chk("irq_masked", 32'h0, {31'h0, o_irq});
    bus(1'h1, `SPSW_REG_IRQ_MASK, 32'h0800, q);
    i_upper_threshold_hit <= 1'h1;
    @(posedge i_ref_clk);
    i_upper_threshold_hit <= 1'h0;
    repeat (5) @(posedge i_ref_clk);
    chk("irq_raised", 32'h1, {31'h0, o_irq});
    bus(1'h0, `SPSW_REG_IRQ_STAT, 32'h0, q);
    chk("irq_stat", 32'h0800, q & 32'h0800);
    repeat (3) @(posedge i_ref_clk);
    chk("irq_cleared", 32'h0, {31'h0, o_irq});
    print_verdict();
  end

  initial begin
    repeat (10000) @(posedge i_ref_clk);
    miscompares++;
    print_verdict();
  end
endmodule // tb_top

bind spsw_status_top spsw_status_monitor u_mon (.i_ref_clk, .i_reset_n, .i_spi_sclk, .i_spi_cs_n, .o_spi_sdo,
  .o_spi_sdo_oe, .i_avs_address, .i_avs_read, .i_avs_write, .o_avs_readdata, .o_avs_waitrequest);

`default_nettype wire
